// *** hdl/line_status_pkg.sv ***
/*
  Constants shared by the line status block: register offsets, status bit
  positions, reset values and frame timing.
  Assumes a single APB clock domain at 100 MHz.
*/
// Behaviour
// - The FIFO error summary bit is set while any stored receive character carries a parity, framing or break mark.
// - The FIFO error summary bit clears only once no character left in the receive FIFO carries any error mark.
// - Outside FIFO mode the transmitter-empty bit is 1 only when holding and shift registers are both empty.
// - In FIFO mode the transmitter-empty bit is 1 whenever the transmit FIFO and the shift register are both empty.
// - Outside FIFO mode the holding-empty bit rises when the holding character moves to the shift register and falls when the CPU loads the holding register.
// - In FIFO mode the holding-empty bit is set while the transmit FIFO is empty and cleared once one byte is written into it.
// - A holding-empty interrupt is raised when the holding-empty bit rises while its interrupt enable is set, and stays until cleared.
// - The break bit is set when the serial input stays low for one full character frame time.
// - In FIFO mode a break, however long, places one single break character in the receive FIFO.
// - The framing error bit is set when a received character lacks a valid stop bit.
// - The parity error bit is set when a received character's parity does not match the configured setting.
// - In FIFO mode parity and framing bits show the error marks of the character at the top of the receive FIFO.
// - The overrun bit is set when a character completes in the shift register while the receive FIFO is full.
// - On overrun the new character is not moved into the FIFO, so the FIFO contents stay intact.
// - The receive-data-ready bit is 1 while the holding register or FIFO holds a character, else 0.
package line_status_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_LINE_STATUS = 8'h00;
  localparam logic [7:0] OFS_RX_DATA = 8'h04;
  localparam logic [7:0] OFS_TX_DATA = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // ---------------------------------------------------------------
  // line status bit positions
  // ---------------------------------------------------------------
  localparam int BIT_DATA_READY = 0;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_PARITY = 2;
  localparam int BIT_FRAMING = 3;
  localparam int BIT_BREAK = 4;
  localparam int BIT_HOLD_EMPTY = 5;
  localparam int BIT_TX_EMPTY = 6;
  localparam int BIT_FIFO_ERROR = 7;

  // control register fields
  localparam int CTL_FIFO_MODE = 0;
  localparam int CTL_HOLD_IE = 1;
  localparam int CTL_PARITY_EN = 2;
  localparam int CTL_PARITY_ODD = 3;
  localparam int CTL_TX_ENABLE = 4;

  // interrupt status bits
  localparam int IRQ_HOLD_EMPTY = 0;
  localparam int IRQ_RX_READY = 1;
  localparam int IRQ_LINE_ERROR = 2;
  localparam int IRQ_WIDTH = 3;

  // stored receive entry: {break, framing, parity, data[7:0]}
  localparam int ENT_PARITY = 8;
  localparam int ENT_FRAMING = 9;
  localparam int ENT_BREAK = 10;
  localparam int ENTRY_W = 11;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h10;
  localparam logic [IRQ_WIDTH-1:0] MASK_RESET = 3'h0;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_HZ = 1_000_000;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam int FRAME_BITS = 10;
  localparam int DATA_BITS = 8;

endpackage : line_status_pkg

// *** hdl/char_fifo.sv ***
/*
  Flip-flop character FIFO with unguarded push and pop strobes.
  Assumes the caller never pops when empty nor pushes when full.
*/
`timescale 1ns/1ps
`default_nettype none
module char_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic empty,
  output logic full,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [$clog2(DEPTH+1)-1:0] cnt_reg;

  // status decode
  assign head = mem_reg[rd_reg];
  assign empty = (cnt_reg == '0);
  assign full = (cnt_reg == DEPTH[$clog2(DEPTH+1)-1:0]);
  assign count = cnt_reg;

  // storage, written only; no reset needed for data
  always_ff @(posedge pclk)
  begin
    if (ce && push)
      mem_reg[wr_reg] <= push_data;
  end

  // pointers wrap at depth, which is a power of two
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else if (ce)
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule : char_fifo
`default_nettype wire

// *** hdl/rx_frame.sv ***
/*
  Serial receiver: samples the serial input mid-bit, checks parity and stop,
  and flags a line held low for a whole frame as a break.
  Assumes serial_input is synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_frame
  import line_status_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic serial_input,
  input wire logic parity_en,
  input wire logic parity_odd,
  output logic done,
  output logic [ENTRY_W-1:0] entry
);
  logic [15:0] cyc_reg;
  logic [3:0] bit_reg;
  logic [9:0] shf_reg;
  logic busy_reg;
  logic brk_hold_reg;
  logic [3:0] nbits;
  logic mid;
  logic par_bad;
  logic all_low;

  // frame length follows parity option
  assign nbits = parity_en ? 4'(FRAME_BITS + 1) : 4'(FRAME_BITS);
  assign mid = (cyc_reg == 16'(BIT_CYC / 2));
  // at the stop sample shf_reg[9:1] holds parity and data, or [9:2] data alone
  assign par_bad = parity_en && (^{shf_reg[9:1], parity_odd});
  assign all_low = parity_en ? (shf_reg[9:1] == '0) : (shf_reg[9:2] == '0);

  // bit timing and shifting; a break repeats nothing until the line idles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc_reg <= '0;
      bit_reg <= '0;
      shf_reg <= '0;
      busy_reg <= 1'b0;
      brk_hold_reg <= 1'b0;
      done <= 1'b0;
      entry <= '0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (serial_input)
        brk_hold_reg <= 1'b0;
      if (!busy_reg)
      begin
        cyc_reg <= '0;
        bit_reg <= '0;
        if (!serial_input && !brk_hold_reg)
          busy_reg <= 1'b1;
      end
      else if (cyc_reg == 16'(BIT_CYC - 1))
        cyc_reg <= '0;
      else
        cyc_reg <= cyc_reg + 16'h0001;
      if (busy_reg && mid)
      begin
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg != 4'h0)
          shf_reg <= {serial_input, shf_reg[9:1]};
        if (bit_reg == nbits - 4'h1)
        begin
          busy_reg <= 1'b0;
          done <= 1'b1;
          entry[DATA_BITS-1:0] <= parity_en ? shf_reg[8:1] : shf_reg[9:2];
          entry[ENT_FRAMING] <= !serial_input;
          entry[ENT_PARITY] <= par_bad;
          entry[ENT_BREAK] <= !serial_input && all_low;
          brk_hold_reg <= !serial_input;
        end
      end
    end
  end
endmodule : rx_frame
`default_nettype wire

// *** hdl/uart_line_status_logic.sv ***
/*
  Line status logic of one serial channel with APB register access,
  receive and transmit FIFOs and a sticky interrupt status.
  Assumes one 100 MHz clock, APB master on pclk, serial input synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_line_status_logic
  import line_status_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int BIT_CYC = BIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_input,
  output logic serial_output,
  output logic irq
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [7:0] control_reg;
  logic [IRQ_WIDTH-1:0] irq_stat_reg;
  logic [IRQ_WIDTH-1:0] irq_mask_reg;
  logic overrun_reg;
  logic parity_reg;
  logic framing_reg;
  logic break_reg;
  logic hold_empty_reg;
  logic [7:0] tx_holding_register;
  logic hold_full_reg;
  logic [7:0] rx_holding_reg;
  logic rx_hold_valid_reg;
  logic [9:0] tx_shift_register;
  logic [3:0] tx_bits_reg;
  logic [15:0] tx_cyc_reg;
  logic setup;
  logic wr_en;
  logic rd_en;
  logic sel_lsr;
  logic sel_rx;
  logic sel_tx;
  logic sel_ctl;
  logic sel_ist;
  logic sel_msk;
  logic unmapped;
  logic fifo_mode;

  assign setup = psel && !penable && clk_en;
  assign wr_en = setup && pwrite;
  assign rd_en = setup && !pwrite;
  assign sel_lsr = (paddr == OFS_LINE_STATUS);
  assign sel_rx = (paddr == OFS_RX_DATA);
  assign sel_tx = (paddr == OFS_TX_DATA);
  assign sel_ctl = (paddr == OFS_CONTROL);
  assign sel_ist = (paddr == OFS_IRQ_STATUS);
  assign sel_msk = (paddr == OFS_IRQ_MASK);
  assign unmapped = !(sel_lsr | sel_rx | sel_tx | sel_ctl | sel_ist | sel_msk);
  assign fifo_mode = control_reg[CTL_FIFO_MODE];

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  logic rx_done;
  logic [ENTRY_W-1:0] rx_entry;
  logic [ENTRY_W-1:0] rxf_head;
  logic rxf_empty;
  logic rxf_full;
  logic [CW-1:0] rxf_count;
  logic rxf_push;
  logic rxf_pop;
  logic [CW-1:0] err_cnt_reg;
  logic err_in;
  logic err_out;
  logic overrun_ev;
  logic rx_ready;

  rx_frame #(.BIT_CYC(BIT_CYC)) u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .serial_input(serial_input),
    .parity_en(control_reg[CTL_PARITY_EN]),
    .parity_odd(control_reg[CTL_PARITY_ODD]),
    .done(rx_done),
    .entry(rx_entry)
  );

  // full fifo drops the newcomer, keeping stored characters intact
  // a read in the same cycle frees the holding register, so no overrun then
  assign overrun_ev = rx_done && (fifo_mode ? rxf_full
                                            : (rx_hold_valid_reg && !(rd_en && sel_rx)));
  assign rxf_push = rx_done && fifo_mode && !rxf_full;
  assign rxf_pop = rd_en && sel_rx && fifo_mode && !rxf_empty;
  assign err_in = |rx_entry[ENT_BREAK:ENT_PARITY];
  assign err_out = |rxf_head[ENT_BREAK:ENT_PARITY];
  assign rx_ready = fifo_mode ? !rxf_empty : rx_hold_valid_reg;

  char_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_rxf (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .push(rxf_push),
    .push_data(rx_entry),
    .pop(rxf_pop),
    .head(rxf_head),
    .empty(rxf_empty),
    .full(rxf_full),
    .count(rxf_count)
  );

  // count of stored characters with error marks; drives the summary bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_cnt_reg <= '0;
    else if (clk_en)
      err_cnt_reg <= err_cnt_reg + CW'(rxf_push && err_in) - CW'(rxf_pop && err_out);
  end

  // non-fifo receive holding register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_holding_reg <= '0;
      rx_hold_valid_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rx_done && !fifo_mode && (!rx_hold_valid_reg || (rd_en && sel_rx)))
      begin
        rx_holding_reg <= rx_entry[DATA_BITS-1:0];
        rx_hold_valid_reg <= 1'b1;
      end
      else if (rd_en && sel_rx)
        rx_hold_valid_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  logic [ENTRY_W-1:0] txf_head;
  logic txf_empty;
  logic txf_full;
  logic txf_push;
  logic txf_pop;
  logic tx_busy;
  logic tx_load;
  logic src_ready;
  logic [7:0] src_byte;
  logic tx_wr;

  assign tx_wr = wr_en && sel_tx;
  assign txf_push = tx_wr && fifo_mode && !txf_full;
  assign tx_busy = (tx_bits_reg != 4'h0);
  assign src_ready = fifo_mode ? !txf_empty : hold_full_reg;
  assign src_byte = fifo_mode ? txf_head[7:0] : tx_holding_register;
  assign tx_load = !tx_busy && src_ready && control_reg[CTL_TX_ENABLE];
  assign txf_pop = tx_load && fifo_mode;

  char_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_txf (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .push(txf_push),
    .push_data({3'h0, pwdata[7:0]}),
    .pop(txf_pop),
    .head(txf_head),
    .empty(txf_empty),
    .full(txf_full),
    .count()
  );

  // holding register and shifter; shifter idles high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_holding_register <= '0;
      hold_full_reg <= 1'b0;
      tx_shift_register <= '1;
      tx_bits_reg <= '0;
      tx_cyc_reg <= '0;
      serial_output <= 1'b1;
    end
    else if (clk_en)
    begin
      if (tx_wr && !fifo_mode)
      begin
        tx_holding_register <= pwdata[7:0];
        hold_full_reg <= 1'b1;
      end
      else if (tx_load && !fifo_mode)
        hold_full_reg <= 1'b0;
      if (tx_load)
      begin
        tx_shift_register <= {1'b1, src_byte, 1'b0};
        tx_bits_reg <= 4'(FRAME_BITS);
        tx_cyc_reg <= '0;
      end
      else if (tx_busy)
      begin
        serial_output <= tx_shift_register[0];
        if (tx_cyc_reg == 16'(BIT_CYC - 1))
        begin
          tx_cyc_reg <= '0;
          tx_shift_register <= {1'b1, tx_shift_register[9:1]};
          tx_bits_reg <= tx_bits_reg - 4'h1;
        end
        else
          tx_cyc_reg <= tx_cyc_reg + 16'h0001;
      end
      else
        serial_output <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // line status flags
  // ---------------------------------------------------------------
  logic lsr_read;
  logic hold_empty_next;
  logic tx_empty;
  logic [7:0] line_status_register;
  logic [ENTRY_W-1:0] err_src;

  assign lsr_read = rd_en && sel_lsr;
  // in fifo mode the marks of the head character are shown
  assign err_src = fifo_mode ? rxf_head : rx_entry;
  assign tx_empty = fifo_mode ? (txf_empty && !tx_busy)
                              : (!hold_full_reg && !tx_busy);
  assign hold_empty_next = fifo_mode ? (txf_empty && !txf_push)
                                     : ((hold_empty_reg || tx_load) && !tx_wr);
  assign line_status_register = {(err_cnt_reg != '0), tx_empty, hold_empty_reg, break_reg,
                                 framing_reg, parity_reg, overrun_reg, rx_ready};

  // sticky error bits (in fifo mode parity, framing and break follow the head); a new event wins over the clear of a status read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overrun_reg <= 1'b0;
      parity_reg <= 1'b0;
      framing_reg <= 1'b0;
      break_reg <= 1'b0;
      hold_empty_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      hold_empty_reg <= hold_empty_next;
      overrun_reg <= overrun_ev || (overrun_reg && !lsr_read);
      if (fifo_mode)
      begin
        parity_reg <= !rxf_empty && rxf_head[ENT_PARITY];
        framing_reg <= !rxf_empty && rxf_head[ENT_FRAMING];
        break_reg <= !rxf_empty && rxf_head[ENT_BREAK];
      end
      else
      begin
        parity_reg <= (rx_done && err_src[ENT_PARITY]) || (parity_reg && !lsr_read);
        framing_reg <= (rx_done && err_src[ENT_FRAMING]) || (framing_reg && !lsr_read);
        break_reg <= (rx_done && err_src[ENT_BREAK]) || (break_reg && !lsr_read);
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts and bus slave
  // ---------------------------------------------------------------
  logic [IRQ_WIDTH-1:0] irq_ev;
  logic [31:0] rd_mux;

  assign irq_ev = {overrun_ev || (rx_done && err_in), rx_done,
                   hold_empty_next && !hold_empty_reg && control_reg[CTL_HOLD_IE]};
  assign rd_mux = sel_lsr ? {24'h0, line_status_register}
                : sel_rx ? {24'h0, (fifo_mode ? rxf_head[7:0] : rx_holding_reg)}
                : sel_ctl ? {24'h0, control_reg}
                : sel_ist ? {29'h0, irq_stat_reg}
                : sel_msk ? {29'h0, irq_mask_reg}
                : 32'h0;

  // zero-wait answer: pready rises one cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_reg <= CONTROL_RESET;
      irq_mask_reg <= MASK_RESET;
      irq_stat_reg <= '0;
      irq <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= setup;
      pslverr <= setup && unmapped;
      if (rd_en)
        prdata <= rd_mux;
      if (wr_en && sel_ctl)
        control_reg <= pwdata[7:0];
      if (wr_en && sel_msk)
        irq_mask_reg <= pwdata[IRQ_WIDTH-1:0];
      irq_stat_reg <= irq_ev | (irq_stat_reg & ~((wr_en && sel_ist) ? pwdata[IRQ_WIDTH-1:0]
                                                                     : '0));
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_lsr_read;
    lsr_read && !overrun_ev;
  endsequence

  AST_OVR_SET: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && overrun_ev |=> overrun_reg) else $error("overrun not flagged");
  AST_OVR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en and s_lsr_read) |=> !overrun_reg) else $error("overrun not cleared by read");
  AST_NO_PUSH_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    rxf_full |-> !rxf_push) else $error("push into full fifo");
  AST_FIFO_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    rxf_empty |-> err_cnt_reg == '0) else $error("error summary with empty fifo");
  AST_TX_EMPTY_FIFO: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_mode && txf_empty && !tx_busy |-> line_status_register[BIT_TX_EMPTY])
    else $error("tx empty bit wrong");
  AST_TX_EMPTY_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !fifo_mode && hold_full_reg |-> !line_status_register[BIT_TX_EMPTY])
    else $error("tx empty with holding full");
  AST_HOLD_WR: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && fifo_mode && txf_push |=> !hold_empty_reg) else $error("hold empty after write");
  AST_RDY: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_mode && !rxf_empty |-> line_status_register[BIT_DATA_READY])
    else $error("data ready missing");
endmodule : uart_line_status_logic
`default_nettype wire

// *** testbench/line_driver.sv ***
/*
  Serial far end: drives the block's receive line, idle high.
  Assumes the bench calls send from one process at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module line_driver #(
  parameter int BIT_CYC = 8
) (
  input wire logic pclk,
  output logic line
);
  initial line = 1'b1;
  // lowest bit first, line back high after the last bit
  task send(input logic [31:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      line <= f[i];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
    @(posedge pclk);
    line <= 1'b1;
  endtask : send
endmodule : line_driver
`default_nettype wire

// *** testbench/test_uart_line_status_logic.sv ***
/*
  Self-checking bench for the line status block: APB master, scenarios.
  Assumes line_driver as the serial far end and one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_uart_line_status_logic;
  import line_status_pkg::*;
  localparam int BC = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, perr, sin, sout, irq;
  logic pe = 1'b0;
  logic ce = 1'b1;
  logic [7:0] tx_seen = 8'h00;
  int tx_frames = 0;
  int error_cnt = 0;
  int num_checks = 0;

  always #5 pclk = ~pclk;

  // small depth so overrun is reached after few characters
  uart_line_status_logic #(.FIFO_DEPTH(4), .BIT_CYC(BC)) uut (.pclk(pclk),
    .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_input(sin),
    .serial_output(sout), .irq(irq));
  line_driver #(.BIT_CYC(BC)) drv (.pclk(pclk), .line(sin));

  // far end of the transmit line: decodes each frame near mid-bit
  initial
  begin
    forever
    begin
      @(posedge pclk);
      if (sout === 1'b0)
      begin
        repeat (BC / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (BC) @(posedge pclk);
          tx_seen[i] = sout;
        end
        repeat (BC) @(posedge pclk);
        tx_frames++;
      end
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task close_out;
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task st(input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, OFS_LINE_STATUS, 32'h0);
    chk(q & {24'h0, m}, {24'h0, e});
  endtask : st

  task rx(input logic [7:0] e);
    apb(1'b0, OFS_RX_DATA, 32'h0);
    chk(q, {24'h0, e});
  endtask : rx

  // parity even when enabled; bad flips it, s is the stop bit
  // under odd parity a set bad gives the clean character
  task ch(input logic [7:0] d, input logic bad, input logic s);
    if (pe)
      drv.send({21'h0, s, ^d ^ bad, d, 1'b0}, 11);
    else
      drv.send({22'h0, s, d, 1'b0}, 10);
    repeat (2 * BC) @(posedge pclk);
  endtask : ch

  // bounded poll; a char takes 10 bit times to drain
  task wait_st(input logic [7:0] e);
    for (int i = 0; i < 300; i++)
    begin
      apb(1'b0, OFS_LINE_STATUS, 32'h0);
      if (q[7:0] === e)
        break;
    end
    chk(q & 32'hFF, {24'h0, e});
  endtask : wait_st

  // irq output lags its status by one cycle
  task ck_irq(input logic e);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : ck_irq

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    st(8'h60, 8'hFF);
    apb(1'b0, OFS_CONTROL, 32'h0);
    chk(q, 32'h10);
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, perr}, 32'h1);
    chk(q, 32'h0);
    // frozen block must ignore a whole character on the line
    ce <= 1'b0;
    ch(8'h5A, 1'b0, 1'b1);
    ce <= 1'b1;
    st(8'h60, 8'hFF);
  endtask : t_reset

  task t_rx_plain;
    ch(8'h5A, 1'b0, 1'b1);
    st(8'h61, 8'h7F);
    rx(8'h5A);
    st(8'h60, 8'h7F);
    ch(8'hC3, 1'b0, 1'b0);
    st(8'h69, 8'h7F);
    st(8'h61, 8'h7F);
    rx(8'hC3);
    apb(1'b1, OFS_CONTROL, 32'h14);
    pe = 1'b1;
    ch(8'h5A, 1'b1, 1'b1);
    st(8'h65, 8'h7F);
    rx(8'h5A);
    apb(1'b1, OFS_CONTROL, 32'h1C);
    ch(8'h5A, 1'b1, 1'b1);
    st(8'h61, 8'h7F);
    rx(8'h5A);
  endtask : t_rx_plain

  // two writes back to back keep holding and shift both busy
  task t_tx(input logic [31:0] c);
    int seen;
    seen = tx_frames;
    apb(1'b1, OFS_CONTROL, c);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    apb(1'b1, OFS_TX_DATA, 32'h55);
    apb(1'b1, OFS_TX_DATA, 32'hA5);
    st(8'h00, 8'h60);
    apb(1'b1, OFS_IRQ_STATUS, 32'h7);
    wait_st(8'h60);
    chk(32'(tx_frames - seen), 32'h2);
    chk({24'h0, tx_seen}, 32'hA5);
    ck_irq(1'b1);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    ck_irq(1'b0);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    ck_irq(1'b1);
    apb(1'b1, OFS_IRQ_STATUS, 32'h1);
    ck_irq(1'b0);
  endtask : t_tx

  task t_fifo;
    apb(1'b1, OFS_CONTROL, 32'h15);
    ch(8'h11, 1'b0, 1'b1);
    ch(8'h22, 1'b1, 1'b1);
    ch(8'h33, 1'b0, 1'b1);
    st(8'hE1, 8'hFF);
    rx(8'h11);
    st(8'hE5, 8'hFF);
    rx(8'h22);
    st(8'h61, 8'hFF);
    rx(8'h33);
    st(8'h60, 8'hFF);
    for (int i = 0; i < 5; i++) ch(8'h41 + 8'(i), 1'b0, 1'b1);
    st(8'h63, 8'hFF);
    for (int i = 0; i < 4; i++) rx(8'h41 + 8'(i));
    st(8'h60, 8'hFF);
    drv.send(32'h0, 30);
    repeat (2 * BC) @(posedge pclk);
    st(8'h11, 8'h11);
    rx(8'h00);
    st(8'h00, 8'h91);
  endtask : t_fifo

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_rx_plain;
    t_tx(32'h12);
    t_tx(32'h13);
    t_fifo;
    close_out;
  end

  // whole run is some 2000 cycles
  initial
  begin
    #200000;
    error_cnt++;
    close_out;
  end
endmodule : test_uart_line_status_logic
`default_nettype wire
